/* pic_ctrl.sv */
// Priority interrupt controller with an APB register slave and a CPU vector port.
// Assumes peripherals hold their pending flags until software clears them.
// Operation
// - Eight sources are arbitrated across four priority levels.
// - Serial and SPI requests share one source with vector 0023H.
// - External 0 vectors to 0003H and is polled first.
// - External 1 vectors to 0013H and is polled fourth.
// - Timer 0 to 000BH, timer 1 to 001BH, timer 2 either flag to 002BH.
// - Brownout vectors to 004BH; counter array flags vector to 0033H.
// - Equal levels follow the fixed poll order ext0 first, timer 2 last.
// - Only the two external sources wake the device from power-down.
// - Main enable bit 7 is the global enable; clear blocks all service.
// - Main enable bit 6 enables the counter array source.
// - Main enable bit 4 enables serial/SPI, bit 5 enables timer 2.
// - Main enable bit 3 enables timer 1, bit 1 enables timer 0.
// - Main enable bit 2 enables external 1, bit 0 enables external 0.
// - Auxiliary enable bit 3 enables the brownout source.
// - Both enable registers reset to 00H and allow bit set, clear, byte writes.
// - Each source has low and high priority bits in separate registers.
// - Brownout priority uses bit 4 of both secondary priority registers.
`timescale 1ns/1ps
module pic_ctrl (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pic_pkg::PIC_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt sources.
	input wire logic ext0_pending,
	input wire logic ext1_pending,
	input wire logic brownout_detect,
	input wire logic timer0_overflow,
	input wire logic timer1_overflow,
	input wire logic timer2_overflow,
	input wire logic timer2_external_flag,
	input wire logic counter_wrap_flag,
	input wire logic [4:0] module_match_flag,
	input wire logic uart_tx_done,
	input wire logic uart_rx_done,
	input wire logic spi_transfer_done,
	// CPU vector port.
	output logic irq_req,
	output logic [15:0] irq_vector,
	output logic [1:0] irq_level,
	output logic [2:0] irq_source,
	input wire logic irq_ack,
	input wire logic irq_return,
	// Power-down wake request.
	output logic power_down_wake
);
	import pic_pkg::*;

	pic_state_s st_r;
	pic_state_s st_nxt;
	logic [PIC_NSRC-1:0] pend;
	logic [PIC_NSRC-1:0] elig;
	logic [PIC_NSRC-1:0][1:0] src_lvl;
	logic svc_any;
	logic [1:0] svc_top;
	logic wr_acc;
	logic setup;
	logic addr_ok;
	logic [7:0] wb;

	pic_arb_if arb ();

	// Winner selection among the eligible sources.
	pic_arbiter #(
		.NSRC(PIC_NSRC)
	) u_arbiter (
		.arb(arb)
	);

	// Pending conditions in poll order; shared sources are merged here.
	assign pend[0] = ext0_pending;
	assign pend[1] = brownout_detect;
	assign pend[2] = timer0_overflow;
	assign pend[3] = ext1_pending;
	assign pend[4] = timer1_overflow;
	assign pend[5] = counter_wrap_flag | (|module_match_flag);
	assign pend[6] = uart_tx_done | uart_rx_done | spi_transfer_done;
	assign pend[7] = timer2_overflow | timer2_external_flag;

	// Per-source gating by individual and global enable, and level from the bit pair.
	for (genvar i = 0; i < PIC_NSRC; i++) begin : g_src
		if (i == PIC_IDX_BO) begin : g_bo
			assign elig[i] = pend[i] & st_r.en_bo & st_r.en_main[PIC_GLOBAL_BIT];
			assign src_lvl[i] = {st_r.bo_hi, st_r.bo_lo};
		end else begin : g_main
			// Bits 0 to 6 of the main register each enable one source.
			assign elig[i] = pend[i] & st_r.en_main[PIC_SRC_BIT[i]]
				& st_r.en_main[PIC_GLOBAL_BIT];
			assign src_lvl[i] = {st_r.prio_hi0[PIC_SRC_BIT[i]],
				st_r.prio_lo0[PIC_SRC_BIT[i]]};
		end
	end

	assign arb.req = elig;
	assign arb.lvl = src_lvl;

	// Highest level currently in service.
	always_comb begin
		svc_any = 1'b0;
		svc_top = 2'h0;
		for (int l = 0; l < PIC_NLVL; l++) begin
			if (st_r.in_svc[l]) begin
				svc_any = 1'b1;
				svc_top = 2'(l);
			end
		end
	end

	// APB phase and address decode; the slave answers in the first access cycle.
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite & addr_ok;
	assign wb = pwdata[7:0];
	always_comb begin
		unique case (paddr)
			PIC_OFF_EN_MAIN, PIC_OFF_EN_AUX, PIC_OFF_PRIO0_LO, PIC_OFF_PRIO0_HI,
			PIC_OFF_PRIO1_LO, PIC_OFF_PRIO1_HI, PIC_OFF_MAIN_SET, PIC_OFF_MAIN_CLR,
			PIC_OFF_AUX_SET, PIC_OFF_AUX_CLR, PIC_OFF_STATUS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// Next state: register writes, read capture, service stack and vector output.
	always_comb begin
		st_nxt = st_r;
		// Read data is captured in the setup cycle and presented during access.
		if (setup) begin
			st_nxt.prdata = 32'h0000_0000;
			unique case (paddr)
				PIC_OFF_EN_MAIN, PIC_OFF_MAIN_SET, PIC_OFF_MAIN_CLR: begin
					st_nxt.prdata[7:0] = st_r.en_main;
				end
				PIC_OFF_EN_AUX, PIC_OFF_AUX_SET, PIC_OFF_AUX_CLR: begin
					st_nxt.prdata[PIC_EBO_BIT] = st_r.en_bo;
				end
				PIC_OFF_PRIO0_LO: st_nxt.prdata[6:0] = st_r.prio_lo0;
				PIC_OFF_PRIO0_HI: st_nxt.prdata[6:0] = st_r.prio_hi0;
				PIC_OFF_PRIO1_LO: st_nxt.prdata[PIC_BO_BIT] = st_r.bo_lo;
				PIC_OFF_PRIO1_HI: st_nxt.prdata[PIC_BO_BIT] = st_r.bo_hi;
				PIC_OFF_STATUS: begin
					st_nxt.prdata[3:0] = st_r.in_svc;
					st_nxt.prdata[PIC_ST_REQ] = st_r.req;
					st_nxt.prdata[PIC_ST_LVL +: 2] = st_r.lvl;
					st_nxt.prdata[PIC_ST_SRC +: 3] = st_r.src;
					st_nxt.prdata[PIC_ST_VEC +: 16] = st_r.vec;
				end
				default: st_nxt.prdata = 32'h0000_0000;
			endcase
		end
		// Whole-byte writes and bitwise set and clear aliases.
		if (wr_acc) begin
			unique case (paddr)
				PIC_OFF_EN_MAIN: st_nxt.en_main = wb;
				PIC_OFF_MAIN_SET: st_nxt.en_main = st_r.en_main | wb;
				PIC_OFF_MAIN_CLR: st_nxt.en_main = st_r.en_main & ~wb;
				PIC_OFF_EN_AUX: st_nxt.en_bo = wb[PIC_EBO_BIT];
				PIC_OFF_AUX_SET: st_nxt.en_bo = st_r.en_bo | wb[PIC_EBO_BIT];
				PIC_OFF_AUX_CLR: st_nxt.en_bo = st_r.en_bo & ~wb[PIC_EBO_BIT];
				PIC_OFF_PRIO0_LO: st_nxt.prio_lo0 = wb[6:0];
				PIC_OFF_PRIO0_HI: st_nxt.prio_hi0 = wb[6:0];
				PIC_OFF_PRIO1_LO: st_nxt.bo_lo = wb[PIC_BO_BIT];
				PIC_OFF_PRIO1_HI: st_nxt.bo_hi = wb[PIC_BO_BIT];
				default: st_nxt.en_main = st_r.en_main;
			endcase
		end
		// A return retires the top level; a same-cycle acknowledge then sets its own.
		if (irq_return && svc_any) begin
			st_nxt.in_svc[svc_top] = 1'b0;
		end
		if (irq_ack && st_r.req) begin
			st_nxt.in_svc[st_r.lvl] = 1'b1;
		end
		// Offer a winner only above the running level; drop it for a cycle after acknowledge.
		st_nxt.req = arb.win_valid && (!svc_any || arb.win_lvl > svc_top)
			&& !(irq_ack && st_r.req);
		st_nxt.src = arb.win_idx;
		st_nxt.lvl = arb.win_lvl;
		st_nxt.vec = PIC_VECTOR[arb.win_idx];
		// Only the external sources raise the wake request.
		st_nxt.wake = elig[PIC_IDX_EXT0] | elig[PIC_IDX_EXT1];
	end

	// State register; every control register resets to zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Output assignments.
	assign prdata = st_r.prdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign irq_req = st_r.req;
	assign irq_vector = st_r.vec;
	assign irq_level = st_r.lvl;
	assign irq_source = st_r.src;
	assign power_down_wake = st_r.wake;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Global enable low means no request on the following cycle.
	a_global_off_noreq: assert property (!st_r.en_main[PIC_GLOBAL_BIT] |=> !irq_req)
		else $error("Request raised while global enable was clear.");

	// Vector matches the winning source.
	a_vector_map: assert property (irq_req |-> irq_vector == PIC_VECTOR[irq_source])
		else $error("Vector does not match the source.");

	// External 0 has vector 0003H.
	a_ext0_vector: assert property (irq_req && irq_source == 3'h0 |-> irq_vector == 16'h0003)
		else $error("External 0 vector is wrong.");

	// Eligible external 0 at the winning level always wins.
	a_poll_first: assert property (irq_req && $past(elig[0]) && $past(src_lvl[0]) == irq_level
		|-> irq_source == 3'h0)
		else $error("External 0 lost a tie.");

	// The winning level is never below that of an eligible timer 2.
	a_level_max: assert property (irq_req && $past(elig[7]) |-> irq_level >= $past(src_lvl[7]))
		else $error("Lower level won over timer 2.");

	// A request always lies above the running level.
	a_preempt_only: assert property (irq_req |-> !$past(svc_any) || irq_level > $past(svc_top))
		else $error("Request does not exceed the running level.");

	// Acknowledge records its level as in service and withdraws the request.
	a_ack_marks: assert property (irq_ack && irq_req |=> st_r.in_svc[$past(irq_level)] && !irq_req)
		else $error("Acknowledge not recorded.");

	// Wake follows only external pending flags.
	a_wake_ext: assert property (power_down_wake |-> $past(ext0_pending || ext1_pending))
		else $error("Wake without an external source.");

	// Set alias adds the written bits.
	a_bit_set: assert property (wr_acc && paddr == PIC_OFF_MAIN_SET
		|=> (st_r.en_main & $past(wb)) == $past(wb))
		else $error("Bit set alias failed.");

	// Brownout disabled never wins.
	a_bo_off: assert property (!st_r.en_bo |=> !(irq_req && irq_source == 3'h1))
		else $error("Disabled brownout was offered.");

	// External 1 has vector 0013H.
	a_ext1_vector: assert property (irq_req && irq_source == 3'h3
		|-> irq_vector == 16'h0013)
		else $error("External 1 vector is wrong.");

	// The shared serial and SPI source has vector 0023H.
	a_serial_vector: assert property (irq_req && irq_source == 3'h6
		|-> irq_vector == 16'h0023)
		else $error("Serial vector is wrong.");

	// Timer 0 has vector 000BH.
	a_timer0_vector: assert property (irq_req && irq_source == 3'h2
		|-> irq_vector == 16'h000B)
		else $error("Timer 0 vector is wrong.");

	// Brownout has vector 004BH.
	a_bo_vector: assert property (irq_req && irq_source == 3'h1
		|-> irq_vector == 16'h004B)
		else $error("Brownout vector is wrong.");

	// A request needs at least one eligible source on the cycle before.
	a_req_eligible: assert property (irq_req
		|-> $past(|elig))
		else $error("Request raised with no eligible source.");

	// Wake is only raised while the global enable was set.
	a_wake_global: assert property (power_down_wake
		|-> $past(st_r.en_main[PIC_GLOBAL_BIT]))
		else $error("Wake raised with global enable clear.");

	// A return clears the highest level in service.
	a_return_retires: assert property (irq_return && svc_any
		|=> !st_r.in_svc[$past(svc_top)])
		else $error("Return did not retire the top level.");

	// A whole-byte write replaces the main enable register.
	a_byte_write: assert property (wr_acc && paddr == PIC_OFF_EN_MAIN
		|=> st_r.en_main == $past(wb))
		else $error("Byte write to the main enable failed.");

	// The clear alias removes the written bits.
	a_bit_clear: assert property (wr_acc && paddr == PIC_OFF_MAIN_CLR
		|=> (st_r.en_main & $past(wb)) == 8'h00)
		else $error("Bit clear alias failed.");

	// A write to the auxiliary enable sets the brownout enable from bit 3.
	a_aux_write: assert property (wr_acc && paddr == PIC_OFF_EN_AUX
		|=> st_r.en_bo == $past(wb[PIC_EBO_BIT]))
		else $error("Auxiliary enable write failed.");

	// Brownout takes its level from its own bit pair.
	a_bo_level: assert property (irq_req && irq_source == 3'h1
		|-> irq_level == $past({st_r.bo_hi, st_r.bo_lo}))
		else $error("Brownout level is wrong.");

	// The serial source is offered only while main bit 4 was set.
	a_serial_enable: assert property (irq_req && irq_source == 3'h6
		|-> $past(st_r.en_main[4]))
		else $error("Serial offered while disabled.");

endmodule : pic_ctrl

/* pic_pkg.sv */
// Constants, register map and state types of the priority interrupt controller.
// Assumes a 32-bit APB register bus and eight polled interrupt sources.
package pic_pkg;

	// Number of sources and priority levels.
	localparam int PIC_NSRC = 8;
	localparam int PIC_NLVL = 4;
	localparam int PIC_AW = 12;

	// Register byte offsets.
	localparam logic [11:0] PIC_OFF_EN_MAIN = 12'h0A8;
	localparam logic [11:0] PIC_OFF_EN_AUX = 12'h0E8;
	localparam logic [11:0] PIC_OFF_PRIO0_LO = 12'h0B8;
	localparam logic [11:0] PIC_OFF_PRIO0_HI = 12'h0BC;
	localparam logic [11:0] PIC_OFF_PRIO1_LO = 12'h0F8;
	localparam logic [11:0] PIC_OFF_PRIO1_HI = 12'h0FC;
	localparam logic [11:0] PIC_OFF_MAIN_SET = 12'h100;
	localparam logic [11:0] PIC_OFF_MAIN_CLR = 12'h104;
	localparam logic [11:0] PIC_OFF_AUX_SET = 12'h108;
	localparam logic [11:0] PIC_OFF_AUX_CLR = 12'h10C;
	localparam logic [11:0] PIC_OFF_STATUS = 12'h110;

	// Reset value of every control register.
	localparam logic [7:0] PIC_RST_BYTE = 8'h00;

	// Field positions.
	localparam int PIC_GLOBAL_BIT = 7;
	localparam int PIC_BO_BIT = 4;
	localparam int PIC_EBO_BIT = 3;
	localparam int PIC_ST_REQ = 4;
	localparam int PIC_ST_LVL = 5;
	localparam int PIC_ST_SRC = 8;
	localparam int PIC_ST_VEC = 16;

	// Poll position of each source: 0 ext0, 1 brownout, 2 timer0, 3 ext1,
	// 4 timer1, 5 counter array, 6 serial/SPI, 7 timer2.
	localparam int PIC_IDX_EXT0 = 0;
	localparam int PIC_IDX_BO = 1;
	localparam int PIC_IDX_EXT1 = 3;

	// Enable and priority bit position in the main registers per poll position.
	localparam int PIC_SRC_BIT [PIC_NSRC] = '{0, 3, 1, 2, 3, 6, 4, 5};

	// Vector address per poll position.
	localparam logic [15:0] PIC_VECTOR [PIC_NSRC] = '{
		16'h0003, 16'h004B, 16'h000B, 16'h0013,
		16'h001B, 16'h0033, 16'h0023, 16'h002B};

	// Complete state of the controller.
	typedef struct packed {
		logic [7:0] en_main;
		logic en_bo;
		logic [6:0] prio_lo0;
		logic [6:0] prio_hi0;
		logic bo_lo;
		logic bo_hi;
		logic [3:0] in_svc;
		logic req;
		logic [2:0] src;
		logic [1:0] lvl;
		logic [15:0] vec;
		logic wake;
		logic [31:0] prdata;
	} pic_state_s;

endpackage : pic_pkg

/* pic_arb_if.sv */
// Carrier between the controller core and its priority arbiter.
// Assumes both ends run on the same clock; the arbiter is combinational.
`timescale 1ns/1ps
interface pic_arb_if;
	import pic_pkg::*;
	logic [PIC_NSRC-1:0] req;
	logic [PIC_NSRC-1:0][1:0] lvl;
	logic win_valid;
	logic [2:0] win_idx;
	logic [1:0] win_lvl;
	modport client (output req, output lvl, input win_valid, input win_idx, input win_lvl);
	modport arbiter (input req, input lvl, output win_valid, output win_idx, output win_lvl);
endinterface : pic_arb_if

/* pic_arbiter.sv */
// Combinational winner picker: highest level first, lowest poll position on ties.
// Assumes requests are already gated by their enables.
`timescale 1ns/1ps
module pic_arbiter #(
	parameter int NSRC = 8
) (
	// Request and winner carrier.
	pic_arb_if.arbiter arb
);
	import pic_pkg::*;

	// The winner index is three bits wide, so at most eight sources fit.
	if (NSRC < 2 || NSRC > PIC_NSRC) begin : g_bad_nsrc
		$error("pic_arbiter: NSRC must lie between 2 and 8.");
	end

	// Walk from the last poll position down so that ties go to the earlier one.
	always_comb begin
		arb.win_valid = 1'b0;
		arb.win_idx = 3'h0;
		arb.win_lvl = 2'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (arb.req[i] && (!arb.win_valid || arb.lvl[i] >= arb.win_lvl)) begin
				arb.win_valid = 1'b1;
				arb.win_idx = 3'(i);
				arb.win_lvl = arb.lvl[i];
			end
		end
	end

endmodule : pic_arbiter

/* pic_cpu_model.sv */
// CPU-side partner of the controller: takes each offered vector after a set wait.
// Assumes the registered request and the ack sampled while the request stands.
`timescale 1ns/1ps
module pic_cpu_model (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Vector port of the controller.
	input wire logic irq_req,
	input wire logic [15:0] irq_vector,
	input wire logic [1:0] irq_level,
	input wire logic [2:0] irq_source,
	output logic irq_ack,
	// Wait setting and record of what was taken.
	input wire logic [3:0] delay,
	output logic [15:0] last_vector,
	output logic [1:0] last_level,
	output logic [2:0] last_source,
	output logic [7:0] n_taken
);
	logic [3:0] cnt_r;

	// Acks a standing request once the wait has run out, so slow CPUs are covered too.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 4'h0;
			irq_ack <= 1'b0;
			last_vector <= 16'h0000;
			last_level <= 2'h0;
			last_source <= 3'h0;
			n_taken <= 8'h00;
		end else if (irq_ack) begin
			// A take only counts if the request still stood at the ack edge.
			irq_ack <= 1'b0;
			cnt_r <= 4'h0;
			if (irq_req) begin
				last_vector <= irq_vector;
				last_level <= irq_level;
				last_source <= irq_source;
				n_taken <= n_taken + 8'h01;
			end
		end else if (irq_req) begin
			if (cnt_r >= delay) begin
				irq_ack <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end
endmodule : pic_cpu_model

/* priority_interrupt_controller_tb_top.sv */
// Self-checking bench for the priority interrupt controller.
// Assumes the zero-wait APB slave and the one-cycle vector handshake.
`timescale 1ns/1ps
module priority_interrupt_controller_tb_top;
	import pic_pkg::*;
	localparam logic [15:0] VEC [8] = '{16'h0003, 16'h004B, 16'h000B, 16'h0013,
		16'h001B, 16'h0033, 16'h0023, 16'h002B};
	localparam int EN [8] = '{0, 0, 1, 2, 3, 6, 4, 5};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req, irq_ack;
	logic irq_return, power_down_wake;
	logic [1:0] alt, irq_level, last_level;
	logic [2:0] irq_source, last_source;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] irq_vector, last_vector;
	logic [7:0] src, n_taken;
	logic [3:0] delay;
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;

	// Device under test; each source bit feeds the inputs of its poll position, picked by alt where shared.
	pic_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext0_pending(src[0]), .ext1_pending(src[3]),
		.brownout_detect(src[1]), .timer0_overflow(src[2]), .timer1_overflow(src[4]),
		.timer2_overflow(src[7] && alt == 2'h0), .timer2_external_flag(src[7] && alt != 2'h0),
		.counter_wrap_flag(src[5] && alt == 2'h0),
		.module_match_flag({src[5] && alt == 2'h1, 3'h0, src[5] && alt == 2'h2}),
		.uart_tx_done(src[6] && alt == 2'h2), .uart_rx_done(src[6] && alt == 2'h0),
		.spi_transfer_done(src[6] && alt == 2'h1),
		.irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
		.irq_source(irq_source),
		.irq_ack(irq_ack), .irq_return(irq_return), .power_down_wake(power_down_wake));

	// CPU partner.
	pic_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
		.irq_vector(irq_vector), .irq_level(irq_level), .irq_source(irq_source),
		.irq_ack(irq_ack), .delay(delay), .last_vector(last_vector),
		.last_level(last_level), .last_source(last_source), .n_taken(n_taken));

	// Compares two values and reports a mismatch.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim

	// One APB transfer; the request is held until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Register write and checked read.
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, {24'h0, d}, q, e);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, {24'h0, x});
	endtask : rd

	// Checks that nothing is offered, waits for a take, ends a routine.
	task automatic quiet;
		logic seen;
		logic [7:0] n0;
		seen = 1'b0;
		n0 = n_taken;
		repeat (6) begin
			@(posedge pclk);
			seen = seen | irq_req;
		end
		chk({31'h0, seen}, 32'h0);
		chk({24'h0, n_taken}, {24'h0, n0});
	endtask : quiet
	task automatic take(input logic [15:0] v, input logic [2:0] s, input logic [1:0] l = 2'h0);
		logic [7:0] n0;
		n0 = n_taken;
		for (int k = 0; k < 40 && n_taken === n0; k++) @(posedge pclk);
		chk({24'h0, n_taken}, {24'h0, n0 + 8'h01});
		chk({16'h0, last_vector}, {16'h0, v});
		chk({27'h0, last_level, last_source}, {27'h0, l, s});
	endtask : take
	task automatic ret;
		irq_return <= 1'b1;
		@(posedge pclk);
		irq_return <= 1'b0;
		@(posedge pclk);
	endtask : ret

	// Reset values, set and clear aliases, unmapped access.
	task automatic t_apb;
		logic [31:0] q;
		logic e;
		rd(PIC_OFF_EN_MAIN, 8'h00);
		rd(PIC_OFF_EN_AUX, 8'h00);
		chk({31'h0, irq_req}, 32'h0);
		wr(PIC_OFF_MAIN_SET, 8'h81);
		rd(PIC_OFF_EN_MAIN, 8'h81);
		wr(PIC_OFF_MAIN_CLR, 8'h01);
		rd(PIC_OFF_EN_MAIN, 8'h80);
		wr(PIC_OFF_AUX_SET, 8'h08);
		rd(PIC_OFF_EN_AUX, 8'h08);
		wr(PIC_OFF_AUX_CLR, 8'h08);
		rd(PIC_OFF_EN_AUX, 8'h00);
		apb(1'b1, 12'hFF0, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		$display("register test done");
	endtask : t_apb

	// Each source alone: gating, vector and wake, over the three flag variants.
	task automatic t_vectors;
		logic [7:0] en;
		for (int a = 0; a < 3; a++) begin
			alt <= 2'(a);
			delay <= (a == 1) ? 4'h3 : 4'h0;
			for (int i = 0; i < 8; i++) begin
				en = (i == 1) ? 8'h00 : 8'h01 << EN[i];
				wr(PIC_OFF_EN_MAIN, en);
				src <= 8'h01 << i;
				quiet();
				wr(PIC_OFF_EN_MAIN, 8'h80);
				quiet();
				wr(PIC_OFF_EN_MAIN, 8'h80 | en);
				if (i == 1) wr(PIC_OFF_EN_AUX, 8'h08);
				take(VEC[i], 3'(i));
				chk({31'h0, power_down_wake}, {31'h0, i == 0 || i == 3});
				src <= 8'h00;
				wr(PIC_OFF_EN_AUX, 8'h00);
				ret();
			end
		end
		$display("vector test done");
	endtask : t_vectors

	// All eight pending at one level are served in poll order.
	task automatic t_order;
		wr(PIC_OFF_EN_MAIN, 8'hFF);
		wr(PIC_OFF_EN_AUX, 8'h08);
		src <= 8'hFF;
		for (int k = 0; k < 8; k++) begin
			take(VEC[k], 3'(k));
			src[k] <= 1'b0;
			ret();
		end
		$display("poll order test done");
	endtask : t_order

	// Levels beat poll order; only a higher level preempts.
	task automatic t_prio;
		wr(PIC_OFF_PRIO1_HI, 8'h10);
		wr(PIC_OFF_PRIO0_LO, 8'h20);
		wr(PIC_OFF_PRIO0_HI, 8'h20);
		src <= 8'h03;
		take(16'h004B, 3'h1, 2'h2);
		quiet();
		src <= 8'h83;
		take(16'h002B, 3'h7, 2'h3);
		src <= 8'h01;
		ret();
		quiet();
		ret();
		take(16'h0003, 3'h0);
		src <= 8'h00;
		ret();
		$display("priority test done");
	endtask : t_prio

	// Clock, watchdog and main sequence.
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			$display("ERROR at %0t: timeout", $time);
			end_sim();
		end
	end
	initial begin
		{pclk, presetn, psel, penable, pwrite, irq_return, alt} = '0;
		paddr = '0;
		pwdata = '0;
		src = '0;
		delay = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_apb();
		t_vectors();
		t_order();
		t_prio();
		end_sim();
	end
endmodule : priority_interrupt_controller_tb_top
